// ==== hdl/fcs_top.sv ====
// Swap, test-bit and unsigned half-to-float unit behind an AXI4-Lite slave
`default_nettype none
module fcs_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [6:0] fp_status_word
);
    fcs_rf_if rf_bus ();

    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [6:0] flags_r;
    logic bad_op_r;
    logic [15:0] operand_r;
    logic [2:0] sel_r;
    logic conv_pend_r;
    logic [2:0] conv_idx_r;
    logic [31:0] conv_val_r;
    logic do_write;
    logic issue;
    logic [15:0] lsw;
    logic [15:0] msw;
    logic [3:0] code;
    logic ct;
    logic is_swap;
    logic is_test;
    logic is_cvm;
    logic is_cvr;
    logic is_conv;
    logic wr_status;
    logic [7:0] ar_ofs;

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic addr_mapped(input logic [7:0] a);
        return a == fcs_pkg::OFS_OPCODE || a == fcs_pkg::OFS_OPERAND ||
               a == fcs_pkg::OFS_STATUS || a == fcs_pkg::OFS_REG_SEL ||
               a == fcs_pkg::OFS_REG_DATA;
    endfunction

    function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // Exact: every 16-bit value fits in the 24-bit significand, no rounding
    function automatic logic [31:0] u16_to_f32(input logic [15:0] v);
        logic [3:0] p;
        logic [31:0] sh;
        p = 4'h0;
        sh = 32'h0000_0000;
        for (int i = 0; i < 16; i++)
        begin
            if (v[i])
                p = 4'(i);
        end
        sh = {16'h0000, v} << (5'h17 - {1'b0, p});
        if (v == 16'h0000)
            return 32'h0000_0000;
        return {1'b0, fcs_pkg::F32_BIAS + {4'h0, p}, sh[22:0]};
    endfunction

    // -------------------------------------------------------------
    // Write channel
    // -------------------------------------------------------------
    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready = !w_hold_r;
    // Commit stalls while a conversion write-back is in flight
    assign do_write = aw_hold_r && w_hold_r && !bvalid_r && !conv_pend_r;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
        end
        else if (s_axi_awvalid && !aw_hold_r)
        begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr[7:0];
        end
        else if (do_write)
            aw_hold_r <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            w_hold_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end
        else if (s_axi_wvalid && !w_hold_r)
        begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        else if (do_write)
            w_hold_r <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= fcs_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_r <= 1'b1;
            if (!addr_mapped(awaddr_r) ||
                (awaddr_r == fcs_pkg::OFS_OPCODE && wstrb_r != 4'hF))
                bresp_r <= fcs_pkg::RESP_SLVERR;
            else
                bresp_r <= fcs_pkg::RESP_OKAY;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // -------------------------------------------------------------
    // Instruction decode
    // -------------------------------------------------------------
    assign lsw = wdata_r[15:0];
    assign msw = wdata_r[31:16];
    assign code = lsw[3:0];
    assign ct = fcs_pkg::cond_true(code, flags_r);
    assign is_swap = lsw[15:4] == fcs_pkg::SWAP_LSW_TOP && msw[15:6] == 10'h000;
    assign is_test = lsw[15:4] == fcs_pkg::TEST_LSW_TOP;
    assign is_cvm = lsw == fcs_pkg::CVT_MEM_LSW && msw[15:11] == 5'h00;
    assign is_cvr = lsw == fcs_pkg::CVT_REG_LSW && msw[15:6] == 10'h000;
    assign is_conv = is_cvm || is_cvr;
    assign issue = do_write && awaddr_r == fcs_pkg::OFS_OPCODE && wstrb_r == 4'hF;
    assign wr_status = do_write && awaddr_r == fcs_pkg::OFS_STATUS;

    // -------------------------------------------------------------
    // Register file ports
    // -------------------------------------------------------------
    // destination in low bits
    assign rf_bus.rd_a_idx = msw[2:0];
    assign rf_bus.rd_b_idx = msw[5:3];
    assign rf_bus.rd_c_idx = sel_r;

    always_comb
    begin
        rf_bus.we_a = 1'b0;
        rf_bus.wa_idx = 3'h0;
        rf_bus.wd_a = 32'h0000_0000;
        rf_bus.we_b = 1'b0;
        rf_bus.wb_idx = 3'h0;
        rf_bus.wd_b = 32'h0000_0000;
        if (conv_pend_r)
        begin
            rf_bus.we_a = 1'b1;
            rf_bus.wa_idx = conv_idx_r;
            rf_bus.wd_a = conv_val_r;
        end
        else if (issue && is_swap && ct)
        begin
            rf_bus.we_a = 1'b1;
            rf_bus.wa_idx = msw[2:0];
            rf_bus.wd_a = rf_bus.rd_b;
            rf_bus.we_b = 1'b1;
            rf_bus.wb_idx = msw[5:3];
            rf_bus.wd_b = rf_bus.rd_a;
        end
        else if (do_write && awaddr_r == fcs_pkg::OFS_REG_DATA)
        begin
            rf_bus.we_a = 1'b1;
            rf_bus.wa_idx = sel_r;
            rf_bus.wd_a = merge32(rf_bus.rd_c, wdata_r, wstrb_r);
        end
    end

    fcs_fp_regs #(
        .DEPTH(8)
    ) u_regs (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .rf(rf_bus.store)
    );

    // -------------------------------------------------------------
    // Conversion pipeline
    // -------------------------------------------------------------
    // Delay-slot collisions are left to software; writes stall meanwhile
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            conv_pend_r <= 1'b0;
            conv_idx_r <= 3'h0;
            conv_val_r <= 32'h0000_0000;
        end
        else if (issue && is_conv)
        begin
            conv_pend_r <= 1'b1;
            if (is_cvm)
            begin
                conv_idx_r <= msw[10:8];
                conv_val_r <= u16_to_f32(operand_r);
            end
            else
            begin
                conv_idx_r <= msw[2:0];
                conv_val_r <= u16_to_f32(rf_bus.rd_b[15:0]);
            end
        end
        else
            conv_pend_r <= 1'b0;
    end

    // -------------------------------------------------------------
    // Status word and software registers
    // -------------------------------------------------------------
    // instructions only write the test bit; zero and sign flags change only on a status write
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            flags_r <= fcs_pkg::FLAGS_RST;
        else if (issue && is_test)
            flags_r[fcs_pkg::FLAG_TF] <= ct;
        else if (wr_status && wstrb_r[0])
            flags_r <= wdata_r[6:0];
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            bad_op_r <= 1'b0;
        else if (issue && !(is_swap || is_test || is_conv))
            bad_op_r <= 1'b1;
        else if (wr_status && wstrb_r[1] && wdata_r[fcs_pkg::BAD_OP_BIT])
            bad_op_r <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            operand_r <= 16'h0000;
            sel_r <= 3'h0;
        end
        else if (do_write && awaddr_r == fcs_pkg::OFS_OPERAND)
            operand_r <= merge32({16'h0000, operand_r}, wdata_r, wstrb_r) >> 0 == 32'h0 ?
                         16'h0000 : merge32({16'h0000, operand_r}, wdata_r, wstrb_r)[15:0];
        else if (do_write && awaddr_r == fcs_pkg::OFS_REG_SEL && wstrb_r[0])
            sel_r <= wdata_r[2:0];
    end

    assign fp_status_word = flags_r;

    // -------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------
    assign s_axi_arready = !rvalid_r;
    assign ar_ofs = s_axi_araddr[7:0];

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= fcs_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= addr_mapped(ar_ofs) ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLVERR;
            case (ar_ofs)
                fcs_pkg::OFS_OPERAND: rdata_r <= {16'h0000, operand_r};
                fcs_pkg::OFS_STATUS: rdata_r <= {23'h000000, bad_op_r, 1'b0, flags_r};
                fcs_pkg::OFS_REG_SEL: rdata_r <= {29'h00000000, sel_r};
                fcs_pkg::OFS_REG_DATA: rdata_r <= rf_bus.rd_c;
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_conv_issue;
        issue && is_conv;
    endsequence
    sequence s_conv_wb;
        conv_pend_r && rf_bus.we_a ##1 !conv_pend_r;
    endsequence

    property p_swap_exchange;
        issue && is_swap && ct && msw[2:0] != msw[5:3] |=>
            rf_bus.rd_a == $past(rf_bus.rd_b) && rf_bus.rd_b == $past(rf_bus.rd_a);
    endproperty
    a_swap_exchange: assert property (p_swap_exchange) else $error("swap did not exchange");

    property p_swap_hold;
        issue && is_swap && !ct |=> $stable(rf_bus.rd_a) && $stable(rf_bus.rd_b);
    endproperty
    a_swap_hold: assert property (p_swap_hold) else $error("false swap changed a register");

    property p_swap_flags;
        issue && is_swap |=> flags_r == $past(flags_r);
    endproperty
    a_swap_flags: assert property (p_swap_flags) else $error("swap changed a flag");

    property p_test_bit;
        issue && is_test |=> flags_r[0] == $past(ct) && flags_r[6:1] == $past(flags_r[6:1]);
    endproperty
    a_test_bit: assert property (p_test_bit) else $error("test bit wrong");

    property p_test_unc;
        issue && is_test && code[3:1] == 3'h7 |=> flags_r[0];
    endproperty
    a_test_unc: assert property (p_test_unc) else $error("always code left test bit clear");

    property p_cond_positive;
        code == 4'h2 |-> ct == (!flags_r[3] && !flags_r[4]);
    endproperty
    a_cond_positive: assert property (p_cond_positive) else $error("positive code wrong");

    property p_cond_at_most;
        code == 4'h5 |-> ct == (flags_r[3] && flags_r[4]);
    endproperty
    a_cond_at_most: assert property (p_cond_at_most) else $error("at-most code wrong");

    property p_conv_two;
        s_conv_issue |=> s_conv_wb;
    endproperty
    a_conv_two: assert property (p_conv_two) else $error("conversion latency wrong");

    property p_conv_flags;
        s_conv_issue |=> $stable(flags_r) [*2];
    endproperty
    a_conv_flags: assert property (p_conv_flags) else $error("conversion changed a flag");

    property p_conv_value;
        issue && is_cvr |=> conv_val_r == u16_to_f32($past(rf_bus.rd_b[15:0]));
    endproperty
    a_conv_value: assert property (p_conv_value) else $error("conversion value wrong");

    property p_one_cycle;
        issue && (is_swap || is_test) |-> !conv_pend_r ##1 !conv_pend_r && bvalid_r;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("single-cycle op stalled");
endmodule
`default_nettype wire

// ==== hdl/fcs_pkg.sv ====
// Constants, register map and condition decoding for the swap/test/convert unit
//
// Overview of operation
// - Exchange opcode: fixed lower word E6E plus condition, upper word two selectors.
// - True condition exchanges the two registers in one cycle; no flag changes.
// - Positive needs zero and sign clear; nonnegative needs sign clear.
// - Below zero needs sign set; at-most-zero needs zero and sign set.
// - Both always codes are true; codes 6 to 9 are reserved.
// - Only always-update may alter zero and sign flags; others leave them. Here no instruction alters them, always-update included.
// - Condition-to-test-bit is one word, fixed upper twelve bits E58.
// - Condition-to-test-bit writes the test bit from the condition, nothing else.
// - Either always code makes condition-to-test-bit set the test bit.
// - Exchange and test-bit instructions finish in one cycle.
// - Memory conversion turns a 16-bit operand into float into selected register.
// - Register conversion turns low 16 source bits into float in destination.
// - Conversions take two cycles; destination written after one delay slot.
// - Conversions alter no status flag.
`default_nettype none
package fcs_pkg;
    // -------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_OPCODE = 8'h00;
    localparam logic [7:0] OFS_OPERAND = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_REG_SEL = 8'h0C;
    localparam logic [7:0] OFS_REG_DATA = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // -------------------------------------------------------------
    // Status word layout
    // -------------------------------------------------------------
    localparam int FLAG_W = 7;
    localparam int FLAG_TF = 0;
    localparam int FLAG_ZI = 1;
    localparam int FLAG_NI = 2;
    localparam int FLAG_ZF = 3;
    localparam int FLAG_NF = 4;
    localparam int FLAG_LUF = 5;
    localparam int FLAG_LVF = 6;
    localparam int BAD_OP_BIT = 8;
    localparam logic [6:0] FLAGS_RST = 7'h00;
    // -------------------------------------------------------------
    // Opcode patterns and sizes
    // -------------------------------------------------------------
    localparam int REG_W = 32;
    localparam int IDX_W = 3;
    localparam logic [11:0] SWAP_LSW_TOP = 12'hE6E;
    localparam logic [11:0] TEST_LSW_TOP = 12'hE58;
    localparam logic [15:0] CVT_MEM_LSW = 16'hE2C4;
    localparam logic [15:0] CVT_REG_LSW = 16'hE68F;
    localparam logic [7:0] F32_BIAS = 8'h7F;
    localparam int CONV_CYCLES = 2;
    // -------------------------------------------------------------
    // Condition codes
    // -------------------------------------------------------------
    localparam logic [3:0] COND_NONZERO = 4'h0;
    localparam logic [3:0] COND_ZERO = 4'h1;
    localparam logic [3:0] COND_POSITIVE = 4'h2;
    localparam logic [3:0] COND_NONNEG = 4'h3;
    localparam logic [3:0] COND_BELOW = 4'h4;
    localparam logic [3:0] COND_AT_MOST = 4'h5;
    localparam logic [3:0] COND_TEST_BIT = 4'hA;
    localparam logic [3:0] COND_TEST_CLR = 4'hB;
    localparam logic [3:0] COND_STICKY_UNDER = 4'hC;
    localparam logic [3:0] COND_STICKY_OVER = 4'hD;
    localparam logic [3:0] COND_ALWAYS = 4'hE;
    localparam logic [3:0] COND_ALWAYS_UPD = 4'hF;

    // Reserved codes evaluate false so a misuse never swaps
    function automatic logic cond_true(input logic [3:0] code, input logic [6:0] f);
        logic r;
        r = 1'b0;
        case (code)
            COND_NONZERO: r = !f[FLAG_ZF];
            COND_ZERO: r = f[FLAG_ZF];
            COND_POSITIVE: r = !f[FLAG_ZF] && !f[FLAG_NF];
            COND_NONNEG: r = !f[FLAG_NF];
            COND_BELOW: r = f[FLAG_NF];
            COND_AT_MOST: r = f[FLAG_ZF] && f[FLAG_NF];
            COND_TEST_BIT: r = f[FLAG_TF];
            COND_TEST_CLR: r = !f[FLAG_TF];
            COND_STICKY_UNDER: r = f[FLAG_LUF];
            COND_STICKY_OVER: r = f[FLAG_LVF];
            COND_ALWAYS: r = 1'b1;
            COND_ALWAYS_UPD: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// ==== hdl/fcs_rf_if.sv ====
// Register file access bundle between the control logic and the register store
`default_nettype none
interface fcs_rf_if;
    logic [fcs_pkg::IDX_W-1:0] rd_a_idx;
    logic [fcs_pkg::IDX_W-1:0] rd_b_idx;
    logic [fcs_pkg::IDX_W-1:0] rd_c_idx;
    logic [fcs_pkg::REG_W-1:0] rd_a;
    logic [fcs_pkg::REG_W-1:0] rd_b;
    logic [fcs_pkg::REG_W-1:0] rd_c;
    logic we_a;
    logic [fcs_pkg::IDX_W-1:0] wa_idx;
    logic [fcs_pkg::REG_W-1:0] wd_a;
    logic we_b;
    logic [fcs_pkg::IDX_W-1:0] wb_idx;
    logic [fcs_pkg::REG_W-1:0] wd_b;
    modport ctrl (output rd_a_idx, rd_b_idx, rd_c_idx, we_a, wa_idx, wd_a, we_b, wb_idx, wd_b,
                  input rd_a, rd_b, rd_c);
    modport store (input rd_a_idx, rd_b_idx, rd_c_idx, we_a, wa_idx, wd_a, we_b, wb_idx, wd_b,
                   output rd_a, rd_b, rd_c);
endinterface
`default_nettype wire

// ==== hdl/fcs_fp_regs.sv ====
// Eight-entry floating-point register store with two write and three read ports
`default_nettype none
module fcs_fp_regs #(
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    fcs_rf_if.store rf
);
    logic [fcs_pkg::REG_W-1:0] mem_r [DEPTH];

    // -------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------
    // Port b wins on a same-index double write; both carry equal data then
    for (genvar g = 0; g < DEPTH; g++)
    begin : g_word
        always_ff @(posedge clk_sys or negedge rstn)
        begin
            if (!rstn)
                mem_r[g] <= 32'h0000_0000;
            else if (rf.we_b && rf.wb_idx == g[fcs_pkg::IDX_W-1:0])
                mem_r[g] <= rf.wd_b;
            else if (rf.we_a && rf.wa_idx == g[fcs_pkg::IDX_W-1:0])
                mem_r[g] <= rf.wd_a;
        end
    end

    // -------------------------------------------------------------
    // Reads straight from the flops
    // -------------------------------------------------------------
    assign rf.rd_a = mem_r[rf.rd_a_idx];
    assign rf.rd_b = mem_r[rf.rd_b_idx];
    assign rf.rd_c = mem_r[rf.rd_c_idx];
endmodule
`default_nettype wire

// ==== verif/fcs_host.sv ====
// Bus master model of the issuing pipeline, with one write task and one read task
`default_nettype none
module fcs_host (
    input wire logic clk_sys,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // ------------------------------------------------
    // Bus cycles
    // ------------------------------------------------
    // Sample at falling edge: readies are stable there
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        logic tb;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tr;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (ta)
                s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the swap, test-bit and conversion unit
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, va, vb, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [6:0] fp_status_word, f;
    logic [3:0] c;
    logic [2:0] a, b;
    logic [15:0] v;
    int failures = 0;
    int checks = 0;
    fcs_top fcs_top_i (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .fp_status_word);
    fcs_host fcs_host_i (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // ------------------------------------------------
    // Expectations
    // ------------------------------------------------
    function automatic logic cnd(input logic [3:0] k, input logic [6:0] g);
        case (k)
            4'h0: return !g[3];
            4'h1: return g[3];
            4'h2: return !g[3] && !g[4];
            4'h3: return !g[4];
            4'h4: return g[4];
            4'h5: return g[3] && g[4];
            4'hA: return g[0];
            4'hB: return !g[0];
            4'hC: return g[5];
            4'hD: return g[6];
            4'hE, 4'hF: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic [31:0] cvt(input logic [15:0] x);
        int p;
        logic [23:0] m;
        p = 15;
        if (x == 16'h0)
            return 32'h0;
        while (!x[p])
            p--;
        m = {8'h0, x} << (23 - p);
        return {1'b0, 8'(8'h7F + p), m[22:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [2:0] i, input logic [31:0] x);
        fcs_host_i.wr(fcs_pkg::OFS_REG_SEL, {29'h0, i}, r);
        fcs_host_i.wr(fcs_pkg::OFS_REG_DATA, x, r);
    endtask
    task automatic get(input logic [2:0] i, output logic [31:0] x);
        fcs_host_i.wr(fcs_pkg::OFS_REG_SEL, {29'h0, i}, r);
        fcs_host_i.rd(fcs_pkg::OFS_REG_DATA, x, r);
    endtask
    task automatic finish_test();
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------------------
    // Clock, watchdog, scenarios
    // ------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = !clk_sys;
    end
    // Whole run needs roughly 15 us
    initial
    begin
        #200000;
        failures++;
        finish_test();
    end
    initial
    begin
        rstn = 1'b0;
        void'($urandom(32'h1BF34413));
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        // Every code, reserved ones too
        for (int i = 0; i < 48; i++)
        begin
            c = 4'(i);
            f = 7'($urandom);
            fcs_host_i.wr(fcs_pkg::OFS_STATUS, {25'h0, f}, r);
            fcs_host_i.wr(fcs_pkg::OFS_OPCODE, {16'h0, fcs_pkg::TEST_LSW_TOP, c}, r);
            chk(fp_status_word, {f[6:1], cnd(c, f)});
            a = 3'($urandom);
            b = a + 3'($urandom_range(7, 1));
            va = $urandom;
            vb = $urandom;
            put(a, va);
            put(b, vb);
            fcs_host_i.wr(fcs_pkg::OFS_OPCODE, {10'h0, b, a, fcs_pkg::SWAP_LSW_TOP, c}, r);
            // Exchange outcome read back after the write response, via select then data
            get(a, d);
            chk(d, cnd(c, fp_status_word) ? vb : va);
            get(b, d);
            chk(d, cnd(c, fp_status_word) ? va : vb);
            v = (i < 2) ? {16{i[0]}} : 16'($urandom);
            fcs_host_i.wr(fcs_pkg::OFS_OPERAND, {16'h0, v}, r);
            // delay slot holds only the response, dest untouched
            fcs_host_i.wr(fcs_pkg::OFS_OPCODE, {5'h0, a, 8'h0, fcs_pkg::CVT_MEM_LSW}, r);
            get(a, d);
            chk(d, cvt(v));
            put(b, {v, ~v});
            fcs_host_i.wr(fcs_pkg::OFS_OPCODE, {10'h0, b, a, fcs_pkg::CVT_REG_LSW}, r);
            get(a, d);
            chk(d, cvt(~v));
            chk(fp_status_word, {f[6:1], cnd(c, f)});
        end
        fcs_host_i.rd(8'h14, d, r);
        chk({d, r}, {32'h0, fcs_pkg::RESP_SLVERR});
        finish_test();
    end
endmodule
`default_nettype wire
